// ---- core/rsc_defs.vh ----
// Purpose: shared constants of the host serial command decoder
// Assumes: 16-bit words, 16-bit memory addresses
// Notes:   included by bare name from the shift and decoder core files; the synchroniser does not include it
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// frame layout
`define RSC_CMD_BITS    4'h8
`define RSC_WORD_BITS   5'h10
`define RSC_WORD_W      16

// pointer command bytes
`define RSC_CMD_ADD1    8'hD0
`define RSC_CMD_ADD2    8'hD8
`define RSC_CMD_ADD4    8'hE0
`define RSC_CMD_RD_PTR  8'h40
`define RSC_CMD_WR_PTR  8'hC0
`define RSC_CMD_RD_INC  8'h48
`define RSC_CMD_WR_INC  8'hC8
`define RSC_CMD_RD_CW   8'h50
`define RSC_CMD_RD_LOG  8'h58
`define RSC_CMD_RD_POLL 8'h60
`define RSC_CMD_RI_0    8'h68
`define RSC_CMD_RI_1    8'h70
`define RSC_CMD_RI_2    8'h78
`define RSC_CMD_WI_0    8'hE8
`define RSC_CMD_WI_1    8'hF0
`define RSC_CMD_WI_2    8'hF8

// fast-access field: bits 7:6 class, 5:2 register, 1:0 zero
`define RSC_FAST_RD_CLS 2'h0
`define RSC_FAST_WR_CLS 2'h2

// addresses
`define RSC_PTR_REG     16'h000F
`define RSC_LOG_LO      16'h0040
`define RSC_LOG_HI      16'h005F

// pointer step modes
`define RSC_STEP_INC1   2'h0
`define RSC_STEP_INC4   2'h1
`define RSC_STEP_DEC    2'h2

`endif

// ---- core/rsc_sync.v ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to ref_clk
// Notes:   nothing but the second stage reads the first
module rsc_sync #(
   parameter W = 3
) (
   input  wire         ref_clk, // block clock
   input  wire         rst_n,   // async reset, active low
   input  wire [W-1:0] pin_i,   // raw pins
   output reg  [W-1:0] sync_q   // synchronised levels
);

   reg [W-1:0] meta_q;

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

endmodule

// ---- core/rsc_shift.v ----
// Purpose: serial framing: command byte, then 16-bit words
// Assumes: mode 0: sample on sck rise, drive on sck fall
// Notes:   strobes are combinational in the rise cycle
`include "rsc_defs.vh"
module rsc_shift (
   input  wire        ref_clk,   // block clock
   input  wire        rst_n,     // async reset, active low
   input  wire        sck_s,     // synchronised serial clock
   input  wire        cs_s,      // synchronised select, high active
   input  wire        mosi_s,    // synchronised data in
   input  wire        tx_load,   // load tx_word for the next fall
   input  wire [15:0] tx_word,   // word to send
   output wire        cmd_done,  // command byte complete
   output wire        word_done, // data word complete
   output wire [15:0] rx_next,   // shift value incl. current bit
   output reg         miso_q     // serial data out
);

   reg        sck_prev_q;
   reg        hdr_q;
   reg  [3:0] cnt_q;
   reg [15:0] rx_q;
   reg [15:0] tx_q;

   wire rise = cs_s & sck_s & ~sck_prev_q;
   wire fall = cs_s & ~sck_s & sck_prev_q;

   // msb first, one bit per clock
   assign rx_next   = {rx_q[14:0], mosi_s};
   assign cmd_done  = rise & hdr_q & (cnt_q == `RSC_CMD_BITS - 4'h1);
   // every word after the command takes 16 clocks
   assign word_done = rise & ~hdr_q & (cnt_q == 4'hF);

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_prev_q <= 1'b0;
         hdr_q      <= 1'b1;
         cnt_q      <= 4'h0;
         rx_q       <= 16'h0000;
         tx_q       <= 16'h0000;
         miso_q     <= 1'b0;
      end
      else
      begin
         sck_prev_q <= sck_s;
         if (!cs_s)
         begin
            hdr_q  <= 1'b1;
            cnt_q  <= 4'h0;
            miso_q <= 1'b0;
         end
         else
         begin
            if (rise)
            begin
               rx_q <= rx_next;
               if (cmd_done)
               begin
                  hdr_q <= 1'b0;
                  cnt_q <= 4'h0;
               end
               else
                  cnt_q <= cnt_q + 4'h1;
            end
            // a load in the fall cycle bypasses the register
            if (fall && tx_load)
            begin
               miso_q <= tx_word[15];
               tx_q   <= {tx_word[14:0], 1'b0};
            end
            else if (tx_load)
               tx_q <= tx_word;
            else if (fall)
            begin
               miso_q <= tx_q[15];
               tx_q   <= {tx_q[14:0], 1'b0};
            end
         end
      end
   end

endmodule

// ---- core/rsc_cmd_decoder.v ----
// Purpose: single-byte host serial command decoder with pointer
// Assumes: memory/register port answers one cycle after mem_rd
// Notes:   sck half period must be at least 100 ns at 40 MHz
`include "rsc_defs.vh"
module rsc_cmd_decoder (
   input  wire        ref_clk,     // 40 MHz block clock
   input  wire        rst_n,       // async reset, active low
   input  wire        spi_sck,     // host serial clock pin
   input  wire        spi_cs_n,    // host chip select pin, low active
   input  wire        spi_mosi,    // host data to device
   output wire        spi_miso,    // device data to host
   output reg         spi_miso_oe, // high while driving miso
   input  wire [15:0] cw_addr,     // current control word address
   input  wire [15:0] log_addr,    // next interrupt log address
   input  wire [15:0] mem_rdata,   // read data, cycle after mem_rd
   output reg  [15:0] mem_addr,    // memory/register address
   output reg         mem_rd,      // read strobe
   output reg         mem_wr,      // write strobe
   output reg  [15:0] mem_wdata,   // write data
   output reg  [15:0] addr_ptr     // primary address pointer
);

   ////////////////////////////////////////////////////////////////
   localparam S_CMD = 2'h0;
   localparam S_IND = 2'h1;
   localparam S_RD  = 2'h2;
   localparam S_WR  = 2'h3;

   localparam K_IGN = 3'h0;
   localparam K_RD  = 3'h1;
   localparam K_WR  = 3'h2;
   localparam K_IRD = 3'h3;
   localparam K_IWR = 3'h4;

   // next address for a given step mode
   function [15:0] step_addr;
      input [15:0] a;
      input [1:0]  m;
      begin
         case (m)
            `RSC_STEP_INC4: step_addr = a + 16'h0004;
            `RSC_STEP_DEC:
               if (a == `RSC_LOG_LO)
                  step_addr = `RSC_LOG_HI;
               else
                  step_addr = a - 16'h0001;
            default:        step_addr = a + 16'h0001;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   wire [2:0]  pins_s;
   wire        sck_s  = pins_s[2];
   wire        cs_s   = pins_s[1];
   wire        mosi_s = pins_s[0];
   wire        cmd_done;
   wire        word_done;
   wire [15:0] rx_next;

   // select synced as active high so reset reads as deselected
   rsc_sync #(
      .W (3)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin_i   ({spi_sck, ~spi_cs_n, spi_mosi}),
      .sync_q  (pins_s)
   );

   reg  [1:0]  state_q;
   reg  [15:0] ptr_q;
   reg  [15:0] fa_q;
   reg  [1:0]  mode_q;
   reg         fast_q;
   reg         rd_wait_q;
   reg  [15:0] pre_q;
   reg         pre_v_q;
   reg         need_q;
   reg         ind_wr_q;

   // register 15 is the pointer itself, answered locally
   wire        self_rd   = (mem_addr == `RSC_PTR_REG);
   wire [15:0] data_word = self_rd ? ptr_q : mem_rdata;
   wire        want      = need_q | word_done;
   wire        tx_load   = (state_q == S_RD) & want & (rd_wait_q | pre_v_q);
   wire [15:0] tx_word   = pre_v_q ? pre_q : data_word;
   wire        rd_issue  = (state_q == S_RD) & ~pre_v_q & ~rd_wait_q & ~mem_rd;

   rsc_shift u_shift (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .sck_s     (sck_s),
      .cs_s      (cs_s),
      .mosi_s    (mosi_s),
      .tx_load   (tx_load),
      .tx_word   (tx_word),
      .cmd_done  (cmd_done),
      .word_done (word_done),
      .rx_next   (rx_next),
      .miso_q    (spi_miso)
   );

   ////////////////////////////////////////////////////////////////
   // command decode, evaluated on the 8th rising clock
   reg [2:0]  dk;
   reg [15:0] da;
   reg [1:0]  dm;
   reg        df;
   reg        dpw;
   reg [15:0] dpv;
   wire [7:0] cmd = rx_next[7:0];

   always @*
   begin
      dk  = K_IGN;
      da  = ptr_q;
      dm  = `RSC_STEP_INC1;
      df  = 1'b0;
      dpw = 1'b0;
      dpv = ptr_q;
      if (cmd[1:0] == 2'h0 && cmd[7:6] == `RSC_FAST_RD_CLS)
      begin
         dk = K_RD;
         da = {12'h000, cmd[5:2]};
         df = 1'b1;
      end
      else if (cmd[1:0] == 2'h0 && cmd[7:6] == `RSC_FAST_WR_CLS)
      begin
         dk = K_WR;
         da = {12'h000, cmd[5:2]};
         df = 1'b1;
      end
      else
      begin
         case (cmd)
            `RSC_CMD_ADD1:
            begin
               dpw = 1'b1;
               dpv = ptr_q + 16'h0001;
            end
            `RSC_CMD_ADD2:
            begin
               dpw = 1'b1;
               dpv = ptr_q + 16'h0002;
            end
            `RSC_CMD_ADD4:
            begin
               dpw = 1'b1;
               dpv = ptr_q + 16'h0004;
            end
            `RSC_CMD_RD_PTR: dk = K_RD;
            `RSC_CMD_WR_PTR: dk = K_WR;
            `RSC_CMD_RD_INC, `RSC_CMD_WR_INC:
            begin
               dk  = cmd[7] ? K_WR : K_RD;
               da  = ptr_q + 16'h0001;
               dpw = 1'b1;
               dpv = da;
            end
            `RSC_CMD_RD_CW:
            begin
               dk  = K_RD;
               da  = cw_addr;
               dpw = 1'b1;
               dpv = cw_addr;
            end
            `RSC_CMD_RD_LOG:
            begin
               dk  = K_RD;
               da  = step_addr(log_addr, `RSC_STEP_DEC);
               dm  = `RSC_STEP_DEC;
               dpw = 1'b1;
               dpv = da;
            end
            `RSC_CMD_RD_POLL:
            begin
               dk = K_RD;
               dm = `RSC_STEP_INC4;
            end
            `RSC_CMD_RI_0, `RSC_CMD_RI_1, `RSC_CMD_RI_2,
            `RSC_CMD_WI_0, `RSC_CMD_WI_1, `RSC_CMD_WI_2:
            begin
               dk = cmd[7] ? K_IWR : K_IRD;
               da = ptr_q + {14'h0000, cmd[4:3] - 2'h1};
            end
            default: dk = K_IGN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q     <= S_CMD;
         ptr_q       <= 16'h0000;
         fa_q        <= 16'h0000;
         mode_q      <= `RSC_STEP_INC1;
         fast_q      <= 1'b0;
         rd_wait_q   <= 1'b0;
         pre_q       <= 16'h0000;
         pre_v_q     <= 1'b0;
         need_q      <= 1'b0;
         ind_wr_q    <= 1'b0;
         mem_addr    <= 16'h0000;
         mem_rd      <= 1'b0;
         mem_wr      <= 1'b0;
         mem_wdata   <= 16'h0000;
         addr_ptr    <= 16'h0000;
         spi_miso_oe <= 1'b0;
      end
      else
      begin
         spi_miso_oe <= cs_s;
         addr_ptr    <= ptr_q;
         mem_rd      <= 1'b0;
         mem_wr      <= 1'b0;
         rd_wait_q   <= mem_rd;
         if (!cs_s)
         begin
            // select released ends any command; late data is dropped
            state_q   <= S_CMD;
            rd_wait_q <= 1'b0;
            pre_v_q   <= 1'b0;
            need_q    <= 1'b0;
         end
         else
         begin
            case (state_q)
               S_CMD:
                  if (cmd_done)
                  begin
                     mode_q <= dm;
                     fast_q <= df;
                     need_q <= 1'b1;
                     ind_wr_q <= (dk == K_IWR);
                     if (dpw)
                        ptr_q <= dpv;
                     case (dk)
                        K_RD:
                        begin
                           // first word fetched at once to meet the next fall
                           mem_addr <= da;
                           mem_rd   <= 1'b1;
                           fa_q     <= step_addr(da, dm);
                           state_q  <= S_RD;
                        end
                        K_WR:
                        begin
                           fa_q    <= da;
                           state_q <= S_WR;
                        end
                        K_IRD, K_IWR:
                        begin
                           mem_addr <= da;
                           mem_rd   <= 1'b1;
                           state_q  <= S_IND;
                        end
                        default:
                           // add-only and unknown bytes wait for release
                           state_q <= S_IND;
                     endcase
                     if (dk == K_IGN)
                        need_q <= 1'b0;
                  end
               S_IND:
                  if (rd_wait_q && need_q)
                  begin
                     ptr_q <= data_word;
                     if (ind_wr_q)
                     begin
                        fa_q    <= data_word;
                        state_q <= S_WR;
                     end
                     else
                     begin
                        // fetch at once so the first bit meets the next fall
                        mem_addr <= data_word;
                        mem_rd   <= 1'b1;
                        fa_q     <= step_addr(data_word, mode_q);
                        state_q  <= S_RD;
                     end
                  end
               S_RD:
               begin
                  if (tx_load)
                  begin
                     need_q  <= 1'b0;
                     pre_v_q <= 1'b0;
                  end
                  else if (word_done)
                     need_q <= 1'b1;
                  if (rd_wait_q && !tx_load)
                  begin
                     pre_q   <= data_word;
                     pre_v_q <= 1'b1;
                  end
                  if (rd_issue)
                  begin
                     mem_addr <= fa_q;
                     mem_rd   <= 1'b1;
                     fa_q     <= step_addr(fa_q, mode_q);
                  end
                  // pointer advances once per word really sent, except on fast-access reads
                  if (word_done && !fast_q)
                     ptr_q <= step_addr(ptr_q, mode_q);
               end
               S_WR:
                  if (word_done)
                  begin
                     mem_addr  <= fa_q;
                     mem_wr    <= 1'b1;
                     mem_wdata <= rx_next;
                     fa_q      <= step_addr(fa_q, `RSC_STEP_INC1);
                     if (fa_q == `RSC_PTR_REG)
                        ptr_q <= rx_next;
                     else if (!fast_q)
                        ptr_q <= step_addr(fa_q, `RSC_STEP_INC1);
                  end
               default:
                  state_q <= S_CMD;
            endcase
         end
      end
   end

endmodule

// ---- verif/rsc_cmd_decoder_asserts.sv ----
// Purpose: port-level assertions for the host serial command decoder
// Assumes: host holds select low for at least 200 ns after the last serial clock fall
// Notes:   bound to rsc_cmd_decoder at the foot of this file
module rsc_cmd_decoder_asserts (
   input logic        ref_clk,     // block clock
   input logic        rst_n,       // async reset, active low
   input logic        spi_sck,     // serial clock pin
   input logic        spi_cs_n,    // select pin, low active
   input logic        spi_mosi,    // host data in
   input logic        spi_miso,    // device data out
   input logic        spi_miso_oe, // miso drive enable
   input logic [15:0] cw_addr,     // control word address
   input logic [15:0] log_addr,    // log next-write address
   input logic [15:0] mem_rdata,   // memory read data
   input logic [15:0] mem_addr,    // memory address
   input logic        mem_rd,      // read strobe
   input logic        mem_wr,      // write strobe
   input logic [15:0] mem_wdata,   // write data
   input logic [15:0] addr_ptr     // primary pointer
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   chk_rd_pulse: assert property (mem_rd |=> !mem_rd)
      else $error("read strobe longer than one cycle");
   chk_wr_pulse: assert property (mem_wr |=> !mem_wr)
      else $error("write strobe longer than one cycle");
   chk_rw_apart: assert property (!(mem_rd && mem_wr))
      else $error("read and write strobes together");
   chk_rd_addr_hold: assert property (mem_rd |=> $stable(mem_addr))
      else $error("address moved right after a read");
   chk_wr_selected: assert property (mem_wr |-> spi_miso_oe)
      else $error("write outside a selected frame");
   chk_oe_on_select: assert property ($fell(spi_cs_n) |-> ##[1:4] spi_miso_oe)
      else $error("miso not driven after select");
   chk_oe_off_deselect: assert property ($rose(spi_cs_n) |-> ##[1:4] !spi_miso_oe)
      else $error("miso still driven after deselect");
   chk_miso_on_fall: assert property ($changed(spi_miso) |-> !spi_sck && !$past(spi_sck, 2))
      else $error("miso changed outside the low clock phase");
   // idle select must freeze the pointer once in-flight work has settled
   chk_ptr_idle_quiet: assert property (spi_cs_n [*8] |=> $stable(addr_ptr))
      else $error("pointer moved while deselected");
endmodule

bind rsc_cmd_decoder rsc_cmd_decoder_asserts rsc_cmd_decoder_asserts_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
   .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .cw_addr(cw_addr), .log_addr(log_addr),
   .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
   .mem_wdata(mem_wdata), .addr_ptr(addr_ptr));

// ---- verif/rsc_host_model.sv ----
// Purpose: host serial master model, 200 ns clock period, mode 0
// Assumes: clock idles low and stands still between frames
// Notes:   miso sampled late in the high phase, as the device answers slowly
module rsc_host_model (
   output logic spi_sck,  // serial clock
   output logic spi_cs_n, // select, low active
   output logic spi_mosi, // data to device
   input  logic spi_miso  // data from device
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // one command per select; wd/rd hold words left aligned
   task automatic frame(input logic [7:0] cmd, input int nw, input logic [63:0] wd,
                        output logic [63:0] rd);
      logic [71:0] sh;
      int          i;
      sh = {cmd, wd};
      rd = 64'h0;
      spi_cs_n = 1'b0;
      for (i = 0; i < 8 + 16 * nw; i++)
      begin
         spi_mosi = sh[71];
         sh = sh << 1;
         #100 spi_sck = 1'b1;
         #100;
         if (i >= 8)
            rd[71 - i] = spi_miso;
         spi_sck = 1'b0;
      end
      #200;
      spi_cs_n = 1'b1;
      // released line: inverted so stale data cannot look valid
      spi_mosi = ~spi_mosi;
      #200;
   endtask
endmodule

// ---- verif/tb.sv ----
// Purpose: self-checking bench for rsc_cmd_decoder
// Assumes: memory model answers one cycle after each read strobe
// Notes:   indirect forms judged on data and pointer
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk;
   logic        rst_n;
   logic        spi_sck;
   logic        spi_cs_n;
   logic        spi_mosi;
   logic        spi_miso;
   logic        spi_miso_oe;
   logic [15:0] cw_addr;
   logic [15:0] log_addr;
   logic [15:0] mem_rdata;
   logic [15:0] mem_addr;
   logic        mem_rd;
   logic        mem_wr;
   logic [15:0] mem_wdata;
   logic [15:0] addr_ptr;
   logic [15:0] mem [0:255];
   logic [63:0] rd;
   int          err_count;
   int          n_compared;
   int          cycles;
   int          wr_seen;
   int          i;

   rsc_cmd_decoder rsc_cmd_decoder_i (.ref_clk(ref_clk), .rst_n(rst_n), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .cw_addr(cw_addr), .log_addr(log_addr), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .addr_ptr(addr_ptr));
   rsc_host_model rsc_host_model_i (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // memory model; stale read data is inverted each cycle so a late sample fails
   always @(posedge ref_clk)
   begin
      cycles++;
      if (mem_rd)
         mem_rdata <= mem[mem_addr[7:0]];
      else
         mem_rdata <= ~mem_rdata;
      if (mem_wr)
      begin
         mem[mem_addr[7:0]] <= mem_wdata;
         wr_seen++;
      end
      if (cycles == 40000)
      begin
         err_count++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] pat(input logic [7:0] a);
      return {8'hA5, a};
   endfunction

   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task end_sim;
      $display("errors %0d compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task xfer(input logic [7:0] cmd, input int nw, input logic [63:0] wd);
      rsc_host_model_i.frame(cmd, nw, wd, rd);
      @(negedge ref_clk);
   endtask

   task setp(input logic [15:0] p);
      xfer(8'hBC, 1, {p, 48'h0});
      check("pointer load", addr_ptr, p);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_fast;
      int r;
      setp(16'h0033);
      for (r = 0; r < 16; r++)
      begin
         xfer({2'b00, r[3:0], 2'b00}, 1, 64'h0);
         check("fast read", rd[63:48], (r == 15) ? 16'h0033 : pat(r[7:0]));
         check("fast read ptr", addr_ptr, 16'h0033);
      end
      xfer(8'h84, 1, {16'h1234, 48'h0});
      check("fast write", mem[1], 16'h1234);
      check("fast write ptr", addr_ptr, 16'h0033);
   endtask

   task t_add;
      int          k;
      int          w;
      logic [15:0] p;
      setp(16'h0020);
      p = 16'h0020;
      w = wr_seen;
      for (k = 0; k < 3; k++)
      begin
         xfer(8'(8'hD0 + 8 * k), 0, 64'h0);
         p = p + 16'(1 << k);
         check("add ptr", addr_ptr, p);
      end
      check("add writes", 16'(wr_seen), 16'(w));
   endtask

   task t_ptr;
      setp(16'h0060);
      xfer(8'h40, 2, 64'h0);
      check("rd w0", rd[63:48], pat(8'h60));
      check("rd w1", rd[47:32], pat(8'h61));
      check("rd ptr", addr_ptr, 16'h0062);
      xfer(8'hC0, 2, {16'hBEEF, 16'hCAFE, 32'h0});
      check("wr w0", mem[8'h62], 16'hBEEF);
      check("wr w1", mem[8'h63], 16'hCAFE);
      check("wr ptr", addr_ptr, 16'h0064);
      xfer(8'h48, 1, 64'h0);
      check("inc rd", rd[63:48], pat(8'h65));
      check("inc rd ptr", addr_ptr, 16'h0066);
      xfer(8'hC8, 1, {16'h5A5A, 48'h0});
      check("inc wr", mem[8'h67], 16'h5A5A);
      check("inc wr ptr", addr_ptr, 16'h0068);
   endtask

   task t_cw;
      cw_addr = 16'h0030;
      xfer(8'h50, 2, 64'h0);
      check("cw w0", rd[63:48], pat(8'h30));
      check("cw w1", rd[47:32], pat(8'h31));
      check("cw ptr", addr_ptr, 16'h0032);
   endtask

   task t_ind;
      int          k;
      logic [15:0] t;
      for (k = 0; k < 6; k++)
      begin
         setp(16'h0080);
         t = 16'h0090 + 16'(k % 3);
         xfer(8'(((k < 3) ? 8'h68 : 8'hE8) + 8 * (k % 3)), 1, {16'hC300 + 16'(k), 48'h0});
         if (k < 3)
         begin
            check("ind read", rd[63:48], pat(t[7:0]));
            check("ind read ptr", addr_ptr, t + 16'h0001);
         end
         else
         begin
            check("ind write", mem[t[7:0]], 16'hC300 + 16'(k));
            check("ind write ptr", addr_ptr, t + 16'h0001);
         end
      end
   endtask

   task t_poll;
      setp(16'h00A0);
      xfer(8'h60, 3, 64'h0);
      check("poll w0", rd[63:48], pat(8'hA0));
      check("poll w1", rd[47:32], pat(8'hA4));
      check("poll w2", rd[31:16], pat(8'hA8));
      check("poll ptr", addr_ptr, 16'h00AC);
   endtask

   task t_log;
      log_addr = 16'h0040;
      xfer(8'h58, 2, 64'h0);
      check("log w0", rd[63:48], pat(8'h5F));
      check("log w1", rd[47:32], pat(8'h5E));
      check("log ptr", addr_ptr, 16'h005D);
      log_addr = 16'h0042;
      xfer(8'h58, 3, 64'h0);
      check("wrap w0", rd[63:48], pat(8'h41));
      check("wrap w1", rd[47:32], pat(8'h40));
      check("wrap w2", rd[31:16], pat(8'h5F));
      check("wrap ptr", addr_ptr, 16'h005E);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      cw_addr = 16'h0000;
      log_addr = 16'h0040;
      mem_rdata = 16'h0000;
      err_count = 0;
      n_compared = 0;
      cycles = 0;
      wr_seen = 0;
      for (i = 0; i < 256; i++)
         mem[i] = pat(i[7:0]);
      for (i = 0; i < 3; i++)
         mem[8'h80 + i] = 16'h0090 + 16'(i);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("ptr after reset", addr_ptr, 16'h0000);
      t_fast;
      t_add;
      t_ptr;
      t_cw;
      t_ind;
      t_poll;
      t_log;
      end_sim;
   end
endmodule
